// ### assbs_cfg.svh
// Register offsets, field positions, reset values and timing counts of the axis stop sequencer.
// Assumes inclusion by its bare name from the package and the top module.
`ifndef ASSBS_CFG_SVH
`define ASSBS_CFG_SVH
`define ASSBS_OFF_CTRL      8'h00
`define ASSBS_OFF_VTHR      8'h04
`define ASSBS_OFF_TOUT      8'h08
`define ASSBS_OFF_STAT      8'h0C
`define ASSBS_OFF_EVT       8'h10
`define ASSBS_OFF_MASK      8'h14
`define ASSBS_OFF_VEL       8'h18
`define ASSBS_OFF_FRESP     8'h1C
`define ASSBS_CTRL_SWEN     0
`define ASSBS_CTRL_IMM      1
`define ASSBS_CTRL_UVM      2
`define ASSBS_CTRL_DISM_LO  3
`define ASSBS_CTRL_DISM_HI  4
`define ASSBS_CTRL_RESET    32'h0000_0004
`define ASSBS_VTHR_RESET    32'h0000_0010
`define ASSBS_TOUT_RESET    32'h0001_E848
`define ASSBS_MASK_RESET    32'h0000_0000
`define ASSBS_FRESP_RESET   32'h0000_0000
`define ASSBS_EVT_UVFAULT   0
`define ASSBS_EVT_UVWARN    1
`define ASSBS_EVT_FAULT     2
`define ASSBS_EVT_STO       3
`define ASSBS_EVT_HWDIS     4
`define ASSBS_EVT_BRAKE     5
`define ASSBS_NEVT          6
`define ASSBS_NFAULT        4
`define ASSBS_CLK_MHZ       125
`define ASSBS_TOUT_UNIT_US  1
`define ASSBS_TOUT_TICKS    (`ASSBS_TOUT_UNIT_US * `ASSBS_CLK_MHZ)
`endif

// ### assbs_pkg.sv
// Types shared by the axis stop and brake sequencer.
// Assumes assbs_cfg.svh is on the include path.
`include "assbs_cfg.svh"
package assbs_pkg;
	typedef enum logic [1:0]
	{
		ASSBS_DM_IMMEDIATE = 2'h0,
		ASSBS_DM_RSVD      = 2'h1,
		ASSBS_DM_CONTROLLED = 2'h2,
		ASSBS_DM_RSVD3     = 2'h3
	} assbs_dismode_t;

	typedef enum logic [1:0]
	{
		ASSBS_FR_DISABLE  = 2'h0,
		ASSBS_FR_DYNBRAKE = 2'h1,
		ASSBS_FR_CONTROL  = 2'h2,
		ASSBS_FR_RSVD     = 2'h3
	} assbs_fresp_t;

	typedef enum logic [4:0]
	{
		ASSBS_ST_IDLE   = 5'h01,
		ASSBS_ST_ACTIVE = 5'h02,
		ASSBS_ST_DECEL  = 5'h04,
		ASSBS_ST_DYN    = 5'h08,
		ASSBS_ST_WAIT   = 5'h10
	} assbs_state_t;

	typedef struct packed
	{
		logic       power_on;
		logic       decel_req;
		logic       dyn_brake;
		logic       brake_apply;
		logic       fault_relay;
	} assbs_drive_t;
endpackage : assbs_pkg

// ### assbs_sequencer.sv
// Axis stop and holding-brake sequencer with an APB register file.
// Assumes CORE_CLK at 125 MHz, pin inputs asynchronous, velocity from same-clock logic.
// What this block does
// - In any stop the brake is applied on standstill velocity or stop timeout, whichever first.
// - Any loss of axis-active triggers brake application.
// - With immediate brake set, faults or hardware disable apply the brake at once.
// - With immediate brake set, safe torque off applies the brake at once.
// - In low-voltage mode 0 any bus undervoltage raises the undervoltage fault.
// - In low-voltage mode 1 undervoltage while not enabled raises only the warning.
// - In mode 1 undervoltage while enabled, or an enable attempt during it, raises the fault.
// - Dropping hardware enable switches the power stage off at once with no deceleration.
// - Safe torque off disables the power stage at once.
// - The disable response select governs only the software disable command, not stop input, fault or pin disables.
// - Disable mode 0 drops the power stage at once, then brakes on standstill or timeout.
// - Disable mode 2 decelerates first, then disables, braking on standstill or timeout.
// - A stop input causes controlled deceleration, then disable and brake.
// - A fault drives the fault relay output to switch the main contactor.
// - Each fault input selects disable, dynamic braking or controlled stop, ending in brake; an undervoltage fault alone always disables.
`include "assbs_cfg.svh"
module assbs_sequencer
(
	input  wire logic        CORE_CLK,
	input  wire logic        RESET_N,
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [7:0]  PADDR,
	input  wire logic [31:0] PWDATA,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	input  wire logic        HW_ENABLE,
	input  wire logic        SAFE_TORQUE_OFF_INPUT,
	input  wire logic        STOP_INPUT,
	input  wire logic        BUS_UNDERVOLTAGE,
	input  wire logic [3:0]  FAULT_IN,
	input  wire logic [15:0] MOTOR_VELOCITY,
	output logic             POWER_STAGE_ON,
	output logic             DECEL_REQUEST,
	output logic             DYNAMIC_BRAKE,
	output logic             BRAKE_APPLY,
	output logic             FAULT_RELAY_OUTPUT,
	output logic             AXIS_ACTIVE,
	output logic             IRQ
);
	logic [31:0]                    ctrl;
	logic [15:0]                    standstill_velocity_threshold;
	logic [31:0]                    standstill_wait_timeout;
	logic [7:0]                     fault_resp;
	logic [`ASSBS_NEVT-1:0]         evt;
	logic [`ASSBS_NEVT-1:0]         evt_mask;
	logic [`ASSBS_NEVT-1:0]         evt_set;
	logic [`ASSBS_NEVT-1:0]         next_evt;
	logic [2:0]                     sync_hwen;
	logic [2:0]                     sync_sto;
	logic [2:0]                     sync_stop;
	logic [2:0]                     sync_uv;
	logic [3:0]                     sync_f [0:2];
	logic                           hw_en;
	logic                           safe_torque_off_input;
	logic                           stop_in;
	logic                           uv;
	logic [3:0]                     flt;
	logic [3:0]                     flt_q;
	logic                           sw_en_q;
	logic                           uv_fault;
	logic                           next_uv_fault;
	logic                           fault_any;
	logic                           at_standstill;
	logic [31:0]                    stop_cnt;
	logic                           timeout_hit;
	logic                           brake;
	logic                           active_q;
	assbs_pkg::assbs_state_t        state;
	assbs_pkg::assbs_state_t        next_state;
	assbs_pkg::assbs_drive_t        drv;
	assbs_pkg::assbs_fresp_t        fsel;
	logic                           immediate_brake_select;
	logic                           bus_low_voltage_mode;
	logic                           software_axis_enable;
	assbs_pkg::assbs_dismode_t      disable_response_select;
	logic                           apb_wr;
	logic                           apb_rd;
	logic                           hit;
	logic [31:0]                    rd_val;

	assign immediate_brake_select  = ctrl[`ASSBS_CTRL_IMM];
	assign bus_low_voltage_mode    = ctrl[`ASSBS_CTRL_UVM];
	assign software_axis_enable    = ctrl[`ASSBS_CTRL_SWEN];
	assign disable_response_select =
		assbs_pkg::assbs_dismode_t'(ctrl[`ASSBS_CTRL_DISM_HI:`ASSBS_CTRL_DISM_LO]);

	// Pins pass three stages; a level counts once the second and third stages agree.
	always_ff @(posedge CORE_CLK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			sync_hwen <= 3'h0;
			sync_sto  <= 3'h7;
			sync_stop <= 3'h0;
			sync_uv   <= 3'h0;
			sync_f[0] <= 4'h0;
			sync_f[1] <= 4'h0;
			sync_f[2] <= 4'h0;
			hw_en     <= 1'b0;
			safe_torque_off_input       <= 1'b1;
			stop_in   <= 1'b0;
			uv        <= 1'b0;
			flt       <= 4'h0;
		end
		else
		begin
			sync_hwen <= {sync_hwen[1:0], HW_ENABLE};
			sync_sto  <= {sync_sto[1:0], SAFE_TORQUE_OFF_INPUT};
			sync_stop <= {sync_stop[1:0], STOP_INPUT};
			sync_uv   <= {sync_uv[1:0], BUS_UNDERVOLTAGE};
			sync_f[0] <= FAULT_IN;
			sync_f[1] <= sync_f[0];
			sync_f[2] <= sync_f[1];
			if (sync_hwen[1] == sync_hwen[2])
				hw_en <= sync_hwen[2];
			if (sync_sto[1] == sync_sto[2])
				safe_torque_off_input <= sync_sto[2];
			if (sync_stop[1] == sync_stop[2])
				stop_in <= sync_stop[2];
			if (sync_uv[1] == sync_uv[2])
				uv <= sync_uv[2];
			for (int i = 0; i < 4; i++)
				if (sync_f[1][i] == sync_f[2][i])
					flt[i] <= sync_f[2][i];
		end
	end

	// Undervoltage fault latches until the condition clears and the axis is not active.
	always_comb
	begin
		next_uv_fault = uv_fault;
		if (uv && !bus_low_voltage_mode)
			next_uv_fault = 1'b1;
		else if (uv && (active_q || (software_axis_enable && !sw_en_q)))
			next_uv_fault = 1'b1;
		else if (!uv && !active_q)
			next_uv_fault = 1'b0;
	end

	always_ff @(posedge CORE_CLK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			uv_fault <= 1'b0;
			sw_en_q  <= 1'b0;
			flt_q    <= 4'h0;
		end
		else
		begin
			uv_fault <= next_uv_fault;
			sw_en_q  <= software_axis_enable;
			flt_q    <= flt;
		end
	end

	assign fault_any     = uv_fault || (flt != 4'h0);
	assign at_standstill = (MOTOR_VELOCITY[15] ? -MOTOR_VELOCITY : MOTOR_VELOCITY)
		<= standstill_velocity_threshold;
	assign timeout_hit   = (stop_cnt >= standstill_wait_timeout);

	// The lowest numbered active fault chooses the response.
	always_comb
	begin
		fsel = assbs_pkg::ASSBS_FR_DISABLE;
		for (int i = `ASSBS_NFAULT - 1; i >= 0; i--)
			if (flt[i])
				fsel = assbs_pkg::assbs_fresp_t'(fault_resp[2*i +: 2]);
		if (uv_fault && flt == 4'h0)
			fsel = assbs_pkg::ASSBS_FR_DISABLE;
	end

	always_comb
	begin
		next_state = state;
		case (state)
			assbs_pkg::ASSBS_ST_IDLE:
				if (hw_en && !safe_torque_off_input && software_axis_enable && !fault_any && !stop_in && !uv)
					next_state = assbs_pkg::ASSBS_ST_ACTIVE;
			assbs_pkg::ASSBS_ST_ACTIVE:
				if (!hw_en || safe_torque_off_input)
					next_state = assbs_pkg::ASSBS_ST_WAIT;
				else if (fault_any)
				begin
					case (fsel)
						assbs_pkg::ASSBS_FR_DYNBRAKE: next_state = assbs_pkg::ASSBS_ST_DYN;
						assbs_pkg::ASSBS_FR_CONTROL:  next_state = assbs_pkg::ASSBS_ST_DECEL;
						default:                      next_state = assbs_pkg::ASSBS_ST_WAIT;
					endcase
				end
				else if (stop_in)
					next_state = assbs_pkg::ASSBS_ST_DECEL;
				else if (!software_axis_enable)
					next_state = (disable_response_select == assbs_pkg::ASSBS_DM_CONTROLLED)
						? assbs_pkg::ASSBS_ST_DECEL
						: assbs_pkg::ASSBS_ST_WAIT;
			assbs_pkg::ASSBS_ST_DECEL, assbs_pkg::ASSBS_ST_DYN:
				if (!hw_en || safe_torque_off_input)
					next_state = assbs_pkg::ASSBS_ST_WAIT;
				else if (at_standstill || timeout_hit)
					next_state = assbs_pkg::ASSBS_ST_IDLE;
			assbs_pkg::ASSBS_ST_WAIT:
				if (brake)
					next_state = assbs_pkg::ASSBS_ST_IDLE;
			default:
				next_state = assbs_pkg::ASSBS_ST_IDLE;
		endcase
	end

	always_ff @(posedge CORE_CLK or negedge RESET_N)
	begin
		if (!RESET_N)
			state <= assbs_pkg::ASSBS_ST_IDLE;
		else
			state <= next_state;
	end

	// Counts from stop initiation; cleared while the axis runs or is idle.
	always_ff @(posedge CORE_CLK or negedge RESET_N)
	begin
		if (!RESET_N)
			stop_cnt <= 32'h0;
		else if (state == assbs_pkg::ASSBS_ST_ACTIVE || state == assbs_pkg::ASSBS_ST_IDLE)
			stop_cnt <= 32'h0;
		else if (!timeout_hit)
			stop_cnt <= stop_cnt + 32'h1;
	end

	// The brake stays open after the axis leaves active until standstill, timeout or an immediate cause; releasing it needs a full enable.
	always_ff @(posedge CORE_CLK or negedge RESET_N)
	begin
		if (!RESET_N)
			brake <= 1'b1;
		else if (next_state == assbs_pkg::ASSBS_ST_ACTIVE)
			brake <= 1'b0;
		else if (state != assbs_pkg::ASSBS_ST_ACTIVE && state != assbs_pkg::ASSBS_ST_IDLE
			&& (at_standstill || timeout_hit))
			brake <= 1'b1;
		else if (immediate_brake_select && (fault_any || !hw_en))
			brake <= 1'b1;
		else if (immediate_brake_select && safe_torque_off_input)
			brake <= 1'b1;
		else if (active_q && next_state == assbs_pkg::ASSBS_ST_IDLE)
			brake <= 1'b1;
	end

	always_ff @(posedge CORE_CLK or negedge RESET_N)
	begin
		if (!RESET_N)
			active_q <= 1'b0;
		else
			active_q <= (next_state == assbs_pkg::ASSBS_ST_ACTIVE);
	end

	always_ff @(posedge CORE_CLK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			// The brake holds the axis for as long as reset is low.
			drv.power_on    <= 1'b0;
			drv.decel_req   <= 1'b0;
			drv.dyn_brake   <= 1'b0;
			drv.brake_apply <= 1'b1;
			drv.fault_relay <= 1'b0;
		end
		else
		begin
			drv.power_on    <= (next_state == assbs_pkg::ASSBS_ST_ACTIVE)
				|| (next_state == assbs_pkg::ASSBS_ST_DECEL);
			drv.decel_req   <= (next_state == assbs_pkg::ASSBS_ST_DECEL);
			drv.dyn_brake   <= (next_state == assbs_pkg::ASSBS_ST_DYN);
			drv.brake_apply <= brake;
			drv.fault_relay <= fault_any;
		end
	end

	assign POWER_STAGE_ON     = drv.power_on;
	assign DECEL_REQUEST      = drv.decel_req;
	assign DYNAMIC_BRAKE      = drv.dyn_brake;
	assign BRAKE_APPLY        = drv.brake_apply;
	assign FAULT_RELAY_OUTPUT = drv.fault_relay;
	assign AXIS_ACTIVE        = active_q;

	// Sticky events; a set in the same cycle as the clearing read wins.
	assign evt_set[`ASSBS_EVT_UVFAULT] = next_uv_fault && !uv_fault;
	assign evt_set[`ASSBS_EVT_UVWARN]  = uv && bus_low_voltage_mode && !next_uv_fault;
	assign evt_set[`ASSBS_EVT_FAULT]   = (flt & ~flt_q) != 4'h0;
	assign evt_set[`ASSBS_EVT_STO]     = safe_torque_off_input && active_q;
	assign evt_set[`ASSBS_EVT_HWDIS]   = !hw_en && active_q;
	assign evt_set[`ASSBS_EVT_BRAKE]   = brake && !drv.brake_apply;

	assign apb_wr = PSEL && PENABLE && PWRITE;
	assign apb_rd = PSEL && PENABLE && !PWRITE;
	always_comb
	begin
		hit    = 1'b1;
		rd_val = 32'h0;
		case (PADDR)
			`ASSBS_OFF_CTRL:  rd_val = ctrl;
			`ASSBS_OFF_VTHR:  rd_val = {16'h0, standstill_velocity_threshold};
			`ASSBS_OFF_TOUT:  rd_val = standstill_wait_timeout;
			`ASSBS_OFF_STAT:  rd_val = {24'h0, uv, safe_torque_off_input, hw_en, uv_fault, state[3:0]};
			`ASSBS_OFF_EVT:   rd_val = {26'h0, evt};
			`ASSBS_OFF_MASK:  rd_val = {26'h0, evt_mask};
			`ASSBS_OFF_VEL:   rd_val = {16'h0, MOTOR_VELOCITY};
			`ASSBS_OFF_FRESP: rd_val = {24'h0, fault_resp};
			default:          hit = 1'b0;
		endcase
	end

	always_ff @(posedge CORE_CLK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			ctrl                          <= `ASSBS_CTRL_RESET;
			standstill_velocity_threshold <= 16'(`ASSBS_VTHR_RESET);
			standstill_wait_timeout       <= `ASSBS_TOUT_RESET;
			evt_mask                      <= `ASSBS_NEVT'(`ASSBS_MASK_RESET);
			fault_resp                    <= 8'(`ASSBS_FRESP_RESET);
		end
		else if (apb_wr && !PREADY)
		begin
			case (PADDR)
				`ASSBS_OFF_CTRL:  ctrl <= {27'h0, PWDATA[4:0]};
				`ASSBS_OFF_VTHR:  standstill_velocity_threshold <= PWDATA[15:0];
				`ASSBS_OFF_TOUT:  standstill_wait_timeout <= PWDATA;
				`ASSBS_OFF_MASK:  evt_mask <= PWDATA[`ASSBS_NEVT-1:0];
				`ASSBS_OFF_FRESP: fault_resp <= PWDATA[7:0];
				default:          ;
			endcase
		end
	end

	always_ff @(posedge CORE_CLK or negedge RESET_N)
	begin
		if (!RESET_N)
			evt <= '0;
		else
			evt <= next_evt;
	end

	// The clearing read and the interrupt share one next value, so IRQ falls with the bits.
	always_comb
	begin
		next_evt = evt | evt_set;
		if (apb_rd && !PREADY && PADDR == `ASSBS_OFF_EVT)
			next_evt = evt_set;
	end

	// One wait state: the answer comes at the second access edge.
	always_ff @(posedge CORE_CLK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			PREADY  <= 1'b0;
			PRDATA  <= 32'h0;
			PSLVERR <= 1'b0;
			IRQ     <= 1'b0;
		end
		else
		begin
			PREADY  <= PSEL && PENABLE && !PREADY;
			PSLVERR <= PSEL && PENABLE && !PREADY && !hit;
			if (apb_rd && !PREADY)
				PRDATA <= rd_val;
			IRQ     <= (next_evt & evt_mask) != '0;
		end
	end
endmodule : assbs_sequencer

// ### assbs_motor.sv
// Motor with holding brake on the far side of the stop sequencer.
// Assumes the sequencer outputs come from the same clock.
module assbs_motor
(
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        power_on,
	input  wire logic        decel,
	input  wire logic        brake,
	input  wire logic        stuck,
	output logic      [15:0] vel
);
	timeunit 1ns;
	timeprecision 1ns;
	// A stuck load keeps turning so that only the stop timeout or an immediate brake cause can end the wait.
	// The control supply is never interrupted, so every stop runs to its end.
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			vel <= 16'h0000;
		else if (power_on && !decel)
			vel <= 16'h0200;
		else if (stuck)
			vel <= vel;
		else if (brake || vel < 16'h0040)
			vel <= 16'h0000;
		else
			vel <= vel - 16'h0040;
	end
endmodule : assbs_motor

// ### assbs_sequencer_chk.sv
// Concurrent checks on the pins of the stop sequencer.
// Assumes one clock domain; bound to every sequencer instance below.
module assbs_sequencer_chk
(
	input wire logic        CORE_CLK,
	input wire logic        RESET_N,
	input wire logic        PSEL,
	input wire logic        PENABLE,
	input wire logic        PREADY,
	input wire logic        HW_ENABLE,
	input wire logic        SAFE_TORQUE_OFF_INPUT,
	input wire logic [3:0]  FAULT_IN,
	input wire logic [15:0] MOTOR_VELOCITY,
	input wire logic        POWER_STAGE_ON,
	input wire logic        DECEL_REQUEST,
	input wire logic        DYNAMIC_BRAKE,
	input wire logic        BRAKE_APPLY,
	input wire logic        FAULT_RELAY_OUTPUT,
	input wire logic        AXIS_ACTIVE
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge CORE_CLK);
	endclocking
	default disable iff (!RESET_N);
	AST_APB_ANSWER: assert property (PSEL && PENABLE && !PREADY |=> PREADY ##1 !PREADY)
		else $error("apb answer timing wrong");
	// Eight cycles cover the pin synchroniser and the output register.
	AST_STO_OFF: assert property (SAFE_TORQUE_OFF_INPUT [*8] |-> !POWER_STAGE_ON)
		else $error("power stage on under safe torque off");
	AST_HWEN_OFF: assert property (!HW_ENABLE [*8] |-> !POWER_STAGE_ON)
		else $error("power stage on without hardware enable");
	AST_STANDSTILL: assert property
		((!AXIS_ACTIVE && MOTOR_VELOCITY == 16'h0000) [*6] |-> BRAKE_APPLY)
		else $error("brake open at standstill");
	// The brake opens one edge after the power stage comes on, so only a second run cycle counts.
	AST_RUN_OPEN: assert property
		((POWER_STAGE_ON && !DECEL_REQUEST && !DYNAMIC_BRAKE) [*2] |-> !BRAKE_APPLY)
		else $error("brake applied while running");
	AST_DECEL_POWER: assert property (DECEL_REQUEST |-> POWER_STAGE_ON)
		else $error("deceleration without power stage");
	AST_DYN_OFF: assert property (DYNAMIC_BRAKE |-> !POWER_STAGE_ON)
		else $error("dynamic braking with power stage on");
	AST_RELAY: assert property ((FAULT_IN != 4'h0) [*8] |-> FAULT_RELAY_OUTPUT)
		else $error("fault relay idle during fault");
	cover property (DECEL_REQUEST && POWER_STAGE_ON);
	cover property (DYNAMIC_BRAKE);
	cover property (FAULT_RELAY_OUTPUT && BRAKE_APPLY);
endmodule : assbs_sequencer_chk

bind assbs_sequencer assbs_sequencer_chk chk (.CORE_CLK(CORE_CLK), .RESET_N(RESET_N),
	.PSEL(PSEL), .PENABLE(PENABLE), .PREADY(PREADY), .HW_ENABLE(HW_ENABLE),
	.SAFE_TORQUE_OFF_INPUT(SAFE_TORQUE_OFF_INPUT), .FAULT_IN(FAULT_IN),
	.MOTOR_VELOCITY(MOTOR_VELOCITY), .POWER_STAGE_ON(POWER_STAGE_ON),
	.DECEL_REQUEST(DECEL_REQUEST), .DYNAMIC_BRAKE(DYNAMIC_BRAKE), .BRAKE_APPLY(BRAKE_APPLY),
	.FAULT_RELAY_OUTPUT(FAULT_RELAY_OUTPUT), .AXIS_ACTIVE(AXIS_ACTIVE));

// ### assbs_sequencer_bench.sv
// Self-checking bench for the stop sequencer driving a motor model.
// Assumes the checker binds itself to the sequencer.
module assbs_sequencer_bench;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int PW = 0, DC = 1, DY = 2, BK = 3, RL = 4, AC = 5, IQ = 6;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        psel = 1'b0;
	logic        pen = 1'b0;
	logic        pwr = 1'b0;
	logic [7:0]  pa = 8'h00;
	logic [31:0] pwd = 32'h0;
	logic        hw = 1'b1;
	logic        safe_torque_off_input = 1'b0;
	logic        stp = 1'b0;
	logic        uv = 1'b0;
	logic [3:0]  flt = 4'h0;
	logic        stuck = 1'b0;
	logic [31:0] q;
	logic        e;
	wire  [31:0] prd;
	wire         prdy;
	wire         perr;
	wire  [15:0] vel;
	wire  [6:0]  o;
	logic [7:0]  ra [5] = '{8'h00, 8'h04, 8'h08, 8'h14, 8'h1C};
	logic [31:0] rv [5] = '{32'h4, 32'h10, 32'h1E848, 32'h0, 32'h0};
	int          fails = 0;
	int          compares = 0;
	always #4 clk = ~clk;
	assbs_sequencer uut (.CORE_CLK(clk), .RESET_N(rst_n), .PSEL(psel), .PENABLE(pen),
		.PWRITE(pwr), .PADDR(pa), .PWDATA(pwd), .PRDATA(prd), .PREADY(prdy), .PSLVERR(perr),
		.HW_ENABLE(hw), .SAFE_TORQUE_OFF_INPUT(safe_torque_off_input), .STOP_INPUT(stp), .BUS_UNDERVOLTAGE(uv),
		.FAULT_IN(flt), .MOTOR_VELOCITY(vel), .POWER_STAGE_ON(o[0]), .DECEL_REQUEST(o[1]),
		.DYNAMIC_BRAKE(o[2]), .BRAKE_APPLY(o[3]), .FAULT_RELAY_OUTPUT(o[4]),
		.AXIS_ACTIVE(o[5]), .IRQ(o[6]));
	assbs_motor motor (.clk(clk), .rst_n(rst_n), .power_on(o[0]), .decel(o[1]),
		.brake(o[3]), .stuck(stuck), .vel(vel));
	task automatic complete_run;
		if (fails == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : complete_run
	task automatic check(input string nm, input logic [31:0] x, input logic [31:0] s);
		compares++;
		if (s !== x)
		begin
			fails++;
			$display("unexpected %s expected %h seen %h", nm, x, s);
		end
	endtask : check
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwr  <= w;
		pa   <= a;
		pwd  <= d;
		@(posedge clk);
		pen <= 1'b1;
		// The iff sees the value of the ready flag from before this edge.
		@(posedge clk iff prdy === 1'b1);
		q = prd;
		e = perr;
		psel <= 1'b0;
		pen  <= 1'b0;
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr
	task automatic rd(input logic [7:0] a);
		apb(1'b0, a, 32'h0);
	endtask : rd
	task automatic rdc(input logic [7:0] a, input logic [31:0] x);
		rd(a);
		check($sformatf("reg %h", a), x, q);
	endtask : rdc
	task automatic await(input int i, input logic v, input int lim);
		int n;
		n = 0;
		while (o[i] !== v && n < lim)
		begin
			@(negedge clk);
			n++;
		end
		check($sformatf("output %0d", i), 32'(v), 32'(o[i]));
	endtask : await
	// Dropping the enable bit first makes every start a fresh enable request.
	task automatic go(input logic [31:0] c);
		wr(8'h00, c);
		wr(8'h00, c | 32'h1);
		await(AC, 1'b1, 40);
		await(BK, 1'b0, 2);
		rd(8'h10);
	endtask : go
	initial
	begin
		#200000;
		fails++;
		complete_run();
	end
	initial
	begin
		@(negedge clk);
		check("brake in reset", 32'h1, 32'(o[BK]));
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		for (int i = 0; i < 5; i++)
			rdc(ra[i], rv[i]);
		rd(8'h20);
		check("pslverr", 32'h1, 32'(e));
		check("unmapped", 32'h0, q);
		wr(8'h08, 32'h0000_00C8);
		go(32'h4);
		wr(8'h00, 32'h4);
		await(PW, 1'b0, 6);
		check("decel", 32'h0, 32'(o[DC]));
		await(BK, 1'b1, 40);
		check("masked irq", 32'h0, 32'(o[IQ]));
		wr(8'h14, 32'h3F);
		await(IQ, 1'b1, 4);
		rdc(8'h10, 32'h20);
		await(IQ, 1'b0, 4);
		go(32'h4);
		stuck <= 1'b1;
		wr(8'h00, 32'h4);
		repeat (100) @(negedge clk);
		check("early brake", 32'h0, 32'(o[BK]));
		await(BK, 1'b1, 150);
		go(32'h4);
		stuck <= 1'b0;
		wr(8'h00, 32'h14);
		await(DC, 1'b1, 6);
		check("power in decel", 32'h1, 32'(o[PW]));
		await(BK, 1'b1, 60);
		await(PW, 1'b0, 4);
		go(32'h4);
		stp <= 1'b1;
		await(DC, 1'b1, 10);
		await(BK, 1'b1, 60);
		await(PW, 1'b0, 4);
		@(posedge clk);
		stp <= 1'b0;
		for (int k = 0; k < 2; k++)
		begin
			go(32'h6);
			stuck <= 1'b1;
			safe_torque_off_input   <= (k == 0);
			hw    <= (k == 0);
			await(PW, 1'b0, 12);
			check("decel", 32'h0, 32'(o[DC]));
			await(BK, 1'b1, 12);
			rd(8'h10);
			check("stop event", 32'h1, 32'(q[3 + k]));
			@(posedge clk);
			stuck <= 1'b0;
			safe_torque_off_input   <= 1'b0;
			hw    <= 1'b1;
		end
		for (int r = 0; r < 3; r++)
		begin
			wr(8'h1C, 32'(r));
			go(32'h4);
			flt <= 4'h1;
			await(r == 0 ? PW : (r == 1 ? DY : DC), r != 0, 12);
			await(RL, 1'b1, 12);
			await(BK, 1'b1, 60);
			@(posedge clk);
			flt <= 4'h0;
		end
		wr(8'h00, 32'h4);
		rd(8'h10);
		uv <= 1'b1;
		repeat (10) @(negedge clk);
		rdc(8'h10, 32'h2);
		wr(8'h00, 32'h5);
		repeat (8) @(negedge clk);
		check("active", 32'h0, 32'(o[AC]));
		rd(8'h10);
		check("uv fault", 32'h1, 32'(q[0]));
		wr(8'h00, 32'h4);
		uv <= 1'b0;
		go(32'h4);
		uv <= 1'b1;
		await(PW, 1'b0, 12);
		rd(8'h10);
		check("uv fault", 32'h1, 32'(q[0]));
		uv <= 1'b0;
		wr(8'h00, 32'h0);
		rd(8'h10);
		uv <= 1'b1;
		repeat (10) @(negedge clk);
		rd(8'h10);
		check("uv fault", 32'h1, 32'(q[0]));
		complete_run();
	end
endmodule : assbs_sequencer_bench
